/* File: hdl/csc_config_chain.sv */
// Serial configuration chains of the cache and system-port controller.
// Assumes chain writes come from processor logic on CLK_I; fill and
// data-valid inputs are pins and are synchronised here.
//
// Behaviour
// - Multibit fields sit least significant bit first in chain position order, except wh_ack_ctrl, whose bit 0 sits above bit 1.
// - Each data-port write loads six bits; six writes fill the 36-bit chain.
// - Forwarding reset delayed by core, internal-clock and frame-clock counts.
// - Extra write cycle bit adds one core cycle to data-control write path.
// - Fill commands delayed by five-bit core cycle count, split in chain.
// - Incoming data-valid sampling delayed by two-bit count of cache clocks.
// - Two-bit field delays external cache clock by zero to three cycles.
// - Cache forwarded clock gets feedback, load and phase-b vectors.
// - System forwarded clock gets feedback, load and phase-b vectors.
// - Five-bit vector sets frame clock to forwarded clock ratio.
// - Two-bit field delays address and data after outgoing forwarded clock.
// - First rewritable chain bit controls cache block parity calculation.
// - One chain bit enables external cache bank mode.
// - Initialize mode writes use four-bit valid, dirty, shared, parity state.
// - Set-dirty field three bits split; invalidate-to-dirty field two bits split.
// - Duplicate fields must equal their primary field; in init mode the marked enable copies must be zero.
// - Enable bit turns cache on; four-bit size; initialize mode bit.
`timescale 1ns/10ps
`include "csc_map.svh"
module csc_config_chain (
    input wire logic CLK_I, // core clock, 250 MHz
    input wire logic RSTN_I, // synchronous reset, active low
    input wire logic CHAIN_WR_I, // one-cycle write to the chain data port
    input wire logic CHAIN_SEL_I, // 1 selects the once_chain chain
    input wire logic [5:0] CHAIN_DATA_I, // six-bit group
    output csc_pkg::csc_many_cfg_t MANY_CFG_O, // rewritable chain settings
    output csc_pkg::csc_once_cfg_t ONCE_CFG_O, // once_chain chain settings
    output logic MANY_LOADED_O, // rewritable chain holds a full load
    output logic ONCE_LOCKED_O, // once_chain chain full and locked
    output logic LOAD_DONE_O, // pulse after a final group
    output logic DUP_MISMATCH_O, // a duplicate differs from its primary
    output logic INIT_DUP_NONZERO_O, // marked duplicate set in init mode
    input wire logic CFR_REQ_I, // request for a forwarding reset
    input wire logic CPU_INTERNAL_CLOCK_TICK_I, // internal clock edge marker
    input wire logic FRAME_CLOCK_TICK_I, // frame clock edge marker
    output logic CLOCK_FORWARD_RESET_O, // delayed forwarding reset pulse
    input wire logic SYS_FILL_CMD_I, // fill command pin
    output logic FILL_CMD_O, // fill command after delay
    input wire logic SYSTEM_DATA_IN_VALID_I, // data-valid pin
    input wire logic CACHE_CLOCK_TICK_I, // cache clock edge marker
    output logic DATA_VALID_O, // data valid after delay
    input wire logic SYSTEM_DATA_CONTROL_I, // data-control write strobe
    output logic SYSTEM_DATA_CONTROL_O, // strobe with optional extra cycle
    input wire logic CACHE_CLK_I, // cache clock before delay
    output logic CACHE_CLK_O, // cache clock after delay
    input wire logic SYS_ADDR_STB_I, // address/data launch strobe
    output logic SYS_ADDR_STB_O // launch strobe after delay
);

    ////////////////////////////////////////////////////////////////////////
    // Chain shifting

    logic many_wr;
    logic once_wr;
    logic [`CSC_MANY_LEN-1:0] many_sh_r;
    logic [`CSC_MANY_LEN-1:0] many_nxt;
    logic [`CSC_MANY_LEN-1:0] many_img_r;
    logic [2:0] many_cnt_r;
    logic many_loaded_r;
    logic [`CSC_ONCE_LEN-1:0] once_sh_r;
    logic [`CSC_ONCE_LEN-1:0] once_nxt;
    logic [`CSC_ONCE_LEN-1:0] once_img_r;
    logic [3:0] once_cnt_r;
    logic once_locked_r;
    logic load_done_r;

    assign many_wr = CHAIN_WR_I & ~CHAIN_SEL_I;
    // Writes after the lock are dropped without trace
    assign once_wr = CHAIN_WR_I & CHAIN_SEL_I & ~once_locked_r;
    // First group written ends at the top, so pre-reversed groups land in order
    assign many_nxt = {many_sh_r[`CSC_MANY_LEN-7:0], CHAIN_DATA_I};
    assign once_nxt = {once_sh_r[`CSC_ONCE_LEN-7:0], CHAIN_DATA_I};

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            many_sh_r <= `CSC_MANY_RESET;
            many_cnt_r <= 3'h0;
        end else if (many_wr) begin
            many_sh_r <= many_nxt;
            many_cnt_r <= (many_cnt_r == `CSC_MANY_LAST) ? 3'h0 : many_cnt_r + 3'h1;
        end
    end

    // Settings change only on the final group, never mid-load
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            many_img_r <= `CSC_MANY_RESET;
            many_loaded_r <= 1'b0;
        end else if (many_wr && many_cnt_r == `CSC_MANY_LAST) begin
            many_img_r <= many_nxt;
            many_loaded_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            once_sh_r <= `CSC_ONCE_RESET;
            once_cnt_r <= 4'h0;
        end else if (once_wr) begin
            once_sh_r <= once_nxt;
            once_cnt_r <= once_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            once_img_r <= `CSC_ONCE_RESET;
            once_locked_r <= 1'b0;
        end else if (once_wr && once_cnt_r == `CSC_ONCE_LAST) begin
            once_img_r <= once_nxt;
            once_locked_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            load_done_r <= 1'b0;
        end else begin
            load_done_r <= (many_wr && many_cnt_r == `CSC_MANY_LAST) ||
                           (once_wr && once_cnt_r == `CSC_ONCE_LAST);
        end
    end

    assign MANY_LOADED_O = many_loaded_r;
    assign ONCE_LOCKED_O = once_locked_r;
    assign LOAD_DONE_O = load_done_r;

    ////////////////////////////////////////////////////////////////////////
    // Field decode, least significant bit at lowest position in all fields but wh_ack_ctrl

    always_comb begin
        MANY_CFG_O.block_parity_ctrl = many_img_r[`CSC_M_PARITY];
        MANY_CFG_O.init_mode = many_img_r[`CSC_M_INIT];
        MANY_CFG_O.ext_cache_size = many_img_r[`CSC_M_SIZE +: 4];
        MANY_CFG_O.ext_cache_on = many_img_r[`CSC_M_ON];
        MANY_CFG_O.wh_ack_ctrl = {many_img_r[`CSC_M_WH1], many_img_r[`CSC_M_WH0]};
        MANY_CFG_O.evict_on = many_img_r[`CSC_M_EVICT];
        MANY_CFG_O.set_dirty_ack = {many_img_r[`CSC_M_SD21 +: 2],
                                    many_img_r[`CSC_M_SD0]};
        MANY_CFG_O.ext_cache_bank_on = many_img_r[`CSC_M_BANK];
        MANY_CFG_O.init_write_state = many_img_r[`CSC_M_WSTS +: 4];
    end

    always_comb begin
        ONCE_CFG_O.fwd_reset_core_delay = once_img_r[`CSC_O_CORE +: 4];
        ONCE_CFG_O.fwd_reset_cpu_delay = once_img_r[`CSC_O_CPU +: 3];
        ONCE_CFG_O.fwd_reset_frame_delay = once_img_r[`CSC_O_FRAME +: 2];
        ONCE_CFG_O.extra_write_cycle = once_img_r[`CSC_O_JIT];
        ONCE_CFG_O.fill_command_delay = {once_img_r[`CSC_O_FILL_HI],
                                         once_img_r[`CSC_O_FILL_LO +: 4]};
        ONCE_CFG_O.data_valid_delay = once_img_r[`CSC_O_DV +: 2];
        ONCE_CFG_O.cache_clock_core_delay = once_img_r[`CSC_O_BCCLK +: 2];
        ONCE_CFG_O.cache_fwd_feedback_sel = once_img_r[`CSC_O_BCFB +: 8];
        ONCE_CFG_O.cache_fwd_load_vec = once_img_r[`CSC_O_BCLD +: 16];
        ONCE_CFG_O.cache_fwd_phase_b_en = once_img_r[`CSC_O_BCPH +: 4];
        ONCE_CFG_O.sysport_fwd_feedback_sel = once_img_r[`CSC_O_SYSFB +: 8];
        ONCE_CFG_O.sysport_fwd_load_vec = once_img_r[`CSC_O_SYSLD +: 16];
        ONCE_CFG_O.sysport_fwd_phase_b_en = once_img_r[`CSC_O_SYSPH +: 4];
        ONCE_CFG_O.frame_ratio_vec = once_img_r[`CSC_O_RATIO +: 5];
        ONCE_CFG_O.sysport_out_core_delay = once_img_r[`CSC_O_SYSCLK +: 2];
    end

    ////////////////////////////////////////////////////////////////////////
    // Duplicate checks; the hardware only reads the primary copies

    logic dup_err;
    logic mbz_err;
    logic dup_err_r;
    logic mbz_err_r;
    logic on_bit;

    assign on_bit = many_img_r[`CSC_M_ON];

    always_comb begin
        mbz_err = many_img_r[`CSC_M_INIT] && (many_img_r[`CSC_M_ON_MBZ +: 3] != 3'h0);
        dup_err = (many_img_r[`CSC_M_ON_DUP_A] != on_bit) ||
                  (many_img_r[`CSC_M_ON_DUP_B] != on_bit) ||
                  (many_img_r[`CSC_M_ON_DUP_C +: 3] != {3{on_bit}}) ||
                  (many_img_r[`CSC_M_SIZE_DUP_A +: 4] != many_img_r[`CSC_M_SIZE +: 4]) ||
                  (many_img_r[`CSC_M_SIZE_DUP_B +: 4] != many_img_r[`CSC_M_SIZE +: 4]) ||
                  (many_img_r[`CSC_M_WH0_DUP] != many_img_r[`CSC_M_WH0]) ||
                  (many_img_r[`CSC_M_INIT_DUP] != many_img_r[`CSC_M_INIT]);
        // Marked copies follow the enable outside init mode
        if (!many_img_r[`CSC_M_INIT] && (many_img_r[`CSC_M_ON_MBZ +: 3] != {3{on_bit}})) begin
            dup_err = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            dup_err_r <= 1'b0;
            mbz_err_r <= 1'b0;
        end else begin
            dup_err_r <= many_loaded_r && dup_err;
            mbz_err_r <= many_loaded_r && mbz_err;
        end
    end

    assign DUP_MISMATCH_O = dup_err_r;
    assign INIT_DUP_NONZERO_O = mbz_err_r;

    ////////////////////////////////////////////////////////////////////////
    // Forwarding reset delay: core cycles, then internal ticks, then frame ticks

    csc_pkg::csc_cfr_state_t cfr_st_r;
    logic [3:0] cfr_cnt_r;
    logic cfr_pulse_r;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            cfr_st_r <= csc_pkg::CSC_ST_IDLE;
            cfr_cnt_r <= 4'h0;
            cfr_pulse_r <= 1'b0;
        end else begin
            cfr_pulse_r <= 1'b0;
            case (cfr_st_r)
                csc_pkg::CSC_ST_IDLE: begin
                    // Requests while a delay runs are ignored
                    if (CFR_REQ_I) begin
                        cfr_st_r <= csc_pkg::CSC_ST_CORE;
                        cfr_cnt_r <= ONCE_CFG_O.fwd_reset_core_delay;
                    end
                end
                csc_pkg::CSC_ST_CORE: begin
                    if (cfr_cnt_r == 4'h0) begin
                        cfr_st_r <= csc_pkg::CSC_ST_CPU;
                        cfr_cnt_r <= {1'b0, ONCE_CFG_O.fwd_reset_cpu_delay};
                    end else begin
                        cfr_cnt_r <= cfr_cnt_r - 4'h1;
                    end
                end
                csc_pkg::CSC_ST_CPU: begin
                    if (cfr_cnt_r == 4'h0) begin
                        cfr_st_r <= csc_pkg::CSC_ST_FRAME;
                        cfr_cnt_r <= {2'b00, ONCE_CFG_O.fwd_reset_frame_delay};
                    end else if (CPU_INTERNAL_CLOCK_TICK_I) begin
                        cfr_cnt_r <= cfr_cnt_r - 4'h1;
                    end
                end
                csc_pkg::CSC_ST_FRAME: begin
                    if (cfr_cnt_r == 4'h0) begin
                        cfr_st_r <= csc_pkg::CSC_ST_IDLE;
                        cfr_pulse_r <= 1'b1;
                    end else if (FRAME_CLOCK_TICK_I) begin
                        cfr_cnt_r <= cfr_cnt_r - 4'h1;
                    end
                end
                default: begin
                    cfr_st_r <= csc_pkg::CSC_ST_IDLE;
                end
            endcase
        end
    end

    assign CLOCK_FORWARD_RESET_O = cfr_pulse_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and programmable delays

    logic fill_meta_r;
    logic fill_s_r;
    logic dv_meta_r;
    logic dv_s_r;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            fill_meta_r <= 1'b0;
            fill_s_r <= 1'b0;
            dv_meta_r <= 1'b0;
            dv_s_r <= 1'b0;
        end else begin
            fill_meta_r <= SYS_FILL_CMD_I;
            fill_s_r <= fill_meta_r;
            dv_meta_r <= SYSTEM_DATA_IN_VALID_I;
            dv_s_r <= dv_meta_r;
        end
    end

    csc_tap_delay #(.SELW(5)) u_fill_dly (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .step_i(1'b1),
        .sel_i(ONCE_CFG_O.fill_command_delay),
        .d_i(fill_s_r),
        .q_o(FILL_CMD_O)
    );

    // Steps on cache clock markers, so the delay is in cache clocks
    csc_tap_delay #(.SELW(2)) u_dv_dly (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .step_i(CACHE_CLOCK_TICK_I),
        .sel_i(ONCE_CFG_O.data_valid_delay),
        .d_i(dv_s_r),
        .q_o(DATA_VALID_O)
    );

    csc_tap_delay #(.SELW(1)) u_dc_dly (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .step_i(1'b1),
        .sel_i(ONCE_CFG_O.extra_write_cycle),
        .d_i(SYSTEM_DATA_CONTROL_I),
        .q_o(SYSTEM_DATA_CONTROL_O)
    );

    csc_tap_delay #(.SELW(2)) u_cclk_dly (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .step_i(1'b1),
        .sel_i(ONCE_CFG_O.cache_clock_core_delay),
        .d_i(CACHE_CLK_I),
        .q_o(CACHE_CLK_O)
    );

    csc_tap_delay #(.SELW(2)) u_stb_dly (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .step_i(1'b1),
        .sel_i(ONCE_CFG_O.sysport_out_core_delay),
        .d_i(SYS_ADDR_STB_I),
        .q_o(SYS_ADDR_STB_O)
    );

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    AST_MANY_HOLD: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        !(many_wr && many_cnt_r == 3'h5) |=> $stable(MANY_CFG_O))
        else $error("rewritable settings changed before final group");

    AST_MANY_WRAP: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (many_wr && many_cnt_r == 3'h5) |=> (many_cnt_r == 3'h0) && MANY_LOADED_O && LOAD_DONE_O)
        else $error("sixth group did not complete the load");

    AST_SIZE_LSB: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (many_wr && many_cnt_r == 3'h5) |=>
            MANY_CFG_O.ext_cache_size == $past(CHAIN_DATA_I[5:2]) &&
            MANY_CFG_O.block_parity_ctrl == $past(CHAIN_DATA_I[0]))
        else $error("size or parity bit taken from wrong position");

    AST_ON_BIT: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (many_wr && many_cnt_r == 3'h5) |=> MANY_CFG_O.ext_cache_on == $past(many_sh_r[0]))
        else $error("enable bit taken from wrong position");

    AST_WSTS: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (many_wr && many_cnt_r == 3'h5) |=>
            MANY_CFG_O.init_write_state == $past(many_sh_r[29:26]))
        else $error("init write state taken from wrong position");

    AST_ONCE_LOCK: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        ONCE_LOCKED_O |=> ONCE_LOCKED_O && $stable(ONCE_CFG_O))
        else $error("once_chain settings changed after lock");

    AST_CFR_CORE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (cfr_st_r == csc_pkg::CSC_ST_IDLE && CFR_REQ_I &&
         ONCE_CFG_O.fwd_reset_core_delay == 4'h2) |=>
            (cfr_st_r == csc_pkg::CSC_ST_CORE) [*3] ##1 (cfr_st_r == csc_pkg::CSC_ST_CPU))
        else $error("core-cycle phase has wrong length");

    AST_CFR_ALL_ZERO: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (cfr_st_r == csc_pkg::CSC_ST_IDLE && CFR_REQ_I &&
         ONCE_CFG_O.fwd_reset_core_delay == 4'h0 &&
         ONCE_CFG_O.fwd_reset_cpu_delay == 3'h0 &&
         ONCE_CFG_O.fwd_reset_frame_delay == 2'h0)
            |-> ##4 CLOCK_FORWARD_RESET_O)
        else $error("forwarding reset not issued after minimum delay");

    AST_EXTRA_CYCLE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (ONCE_LOCKED_O && ONCE_CFG_O.extra_write_cycle) |=>
            SYSTEM_DATA_CONTROL_O == $past(SYSTEM_DATA_CONTROL_I))
        else $error("extra write cycle not added");

    AST_FILL_DLY: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (ONCE_LOCKED_O && ONCE_CFG_O.fill_command_delay == 5'h11) |->
            ##17 FILL_CMD_O == $past(fill_s_r, 17))
        else $error("fill command delay wrong");

    AST_DV_ZERO: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (ONCE_CFG_O.data_valid_delay == 2'h0) |-> DATA_VALID_O == dv_s_r)
        else $error("data valid delayed with zero setting");

    // Only meaningful once two cache clock markers have passed in a row
    AST_DV_DLY: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (ONCE_LOCKED_O && ONCE_CFG_O.data_valid_delay == 2'h2 &&
         $past(CACHE_CLOCK_TICK_I) && $past(CACHE_CLOCK_TICK_I, 2)) |->
            DATA_VALID_O == $past(dv_s_r, 2))
        else $error("data valid delay wrong");

    AST_CCLK_DLY: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (ONCE_LOCKED_O && ONCE_CFG_O.cache_clock_core_delay == 2'h1) |=>
            CACHE_CLK_O == $past(CACHE_CLK_I))
        else $error("cache clock delay wrong");

    AST_STB_DLY: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
        (ONCE_LOCKED_O && ONCE_CFG_O.sysport_out_core_delay == 2'h3) |->
            ##3 SYS_ADDR_STB_O == $past(SYS_ADDR_STB_I, 3))
        else $error("launch strobe delay wrong");

    COV_MANY_LOAD: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        $rose(MANY_LOADED_O));
    COV_ONCE_LOCK: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        $rose(ONCE_LOCKED_O));
    COV_CFR: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        CLOCK_FORWARD_RESET_O);
    COV_DUP: cover property (@(posedge CLK_I) disable iff (!RSTN_I)
        $rose(DUP_MISMATCH_O));

endmodule : csc_config_chain

/* File: hdl/csc_map.svh */
// Bit positions, lengths and reset images of the two configuration chains.
// Assumes the includer uses the positions as part-select bases into chain images.
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH

`define CSC_GROUP_W 6
`define CSC_MANY_LEN 36
`define CSC_MANY_LAST 3'h5
`define CSC_ONCE_LEN 96
`define CSC_ONCE_LAST 4'hF
`define CSC_MANY_RESET 36'h0
`define CSC_ONCE_RESET 96'h0

// Rewritable chain, position 0 is the first bit shifted through
`define CSC_M_PARITY 0
`define CSC_M_INIT 1
`define CSC_M_SIZE 2
`define CSC_M_ON 6
`define CSC_M_ON_DUP_A 7
`define CSC_M_SIZE_DUP_A 8
`define CSC_M_ON_MBZ 12
`define CSC_M_WH1 15
`define CSC_M_EVICT 16
`define CSC_M_ON_DUP_B 17
`define CSC_M_WH0 18
`define CSC_M_ON_DUP_C 19
`define CSC_M_SD0 22
`define CSC_M_WH0_DUP 23
`define CSC_M_SD21 24
`define CSC_M_BANK 26
`define CSC_M_SIZE_DUP_B 27
`define CSC_M_INIT_DUP 31
`define CSC_M_WSTS 32

// Once_chain chain; positions 0 to 3 stand for the earlier entries
`define CSC_O_CORE 4
`define CSC_O_CPU 8
`define CSC_O_FRAME 11
`define CSC_O_JIT 18
`define CSC_O_FILL_LO 20
`define CSC_O_DV 24
`define CSC_O_BCCLK 28
`define CSC_O_BCFB 30
`define CSC_O_BCLD 38
`define CSC_O_BCPH 54
`define CSC_O_SYSCLK 60
`define CSC_O_SYSFB 62
`define CSC_O_SYSLD 70
`define CSC_O_SYSPH 86
`define CSC_O_RATIO 90
`define CSC_O_FILL_HI 95

`endif

/* File: hdl/csc_pkg.sv */
// Types shared by the configuration chain block.
// Assumes the map header supplies all positions and lengths.
package csc_pkg;

    typedef struct packed {
        logic block_parity_ctrl;
        logic init_mode;
        logic [3:0] ext_cache_size;
        logic ext_cache_on;
        logic [1:0] wh_ack_ctrl;
        logic evict_on;
        logic [2:0] set_dirty_ack;
        logic ext_cache_bank_on;
        logic [3:0] init_write_state;
    } csc_many_cfg_t;

    typedef struct packed {
        logic [3:0] fwd_reset_core_delay;
        logic [2:0] fwd_reset_cpu_delay;
        logic [1:0] fwd_reset_frame_delay;
        logic extra_write_cycle;
        logic [4:0] fill_command_delay;
        logic [1:0] data_valid_delay;
        logic [1:0] cache_clock_core_delay;
        logic [7:0] cache_fwd_feedback_sel;
        logic [15:0] cache_fwd_load_vec;
        logic [3:0] cache_fwd_phase_b_en;
        logic [7:0] sysport_fwd_feedback_sel;
        logic [15:0] sysport_fwd_load_vec;
        logic [3:0] sysport_fwd_phase_b_en;
        logic [4:0] frame_ratio_vec;
        logic [1:0] sysport_out_core_delay;
    } csc_once_cfg_t;

    typedef enum logic [1:0] {
        CSC_ST_IDLE = 2'b00,
        CSC_ST_CORE = 2'b01,
        CSC_ST_CPU = 2'b10,
        CSC_ST_FRAME = 2'b11
    } csc_cfr_state_t;

endpackage : csc_pkg

/* File: hdl/csc_tap_delay.sv */
// Programmable delay line: output is the input delayed by sel_i steps.
// Assumes step_i is a same-clock qualifier; sel_i held stable while in use.
`timescale 1ns/10ps
module csc_tap_delay #(
    parameter int SELW = 2,
    parameter int DEPTH = (1 << SELW) - 1
) (
    input wire logic clk_i, // core clock
    input wire logic rstn_i, // synchronous reset, active low
    input wire logic step_i, // advance the line by one step
    input wire logic [SELW-1:0] sel_i, // delay in steps
    input wire logic d_i, // signal in
    output logic q_o // delayed signal
);
    logic [DEPTH:0] line;

    assign line[0] = d_i;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            line[DEPTH:1] <= '0;
        end else if (step_i) begin
            line[DEPTH:1] <= line[DEPTH-1:0];
        end
    end

    // Zero delay passes straight through, so the output is not always a flop
    assign q_o = line[sel_i];

endmodule : csc_tap_delay

/* File: verif/csc_config_chain_tb.sv */
// Self-checking bench for the configuration chain block.
// Assumes csc_loader stands in for the loader code; tick markers run every cycle.
`timescale 1ns/10ps
`include "csc_map.svh"
module csc_config_chain_tb;
    logic clk = 1'h0;
    logic rstn;
    logic [5:0] pin = 6'h0;
    logic [5:0] out;
    logic wr, sel, loaded, locked, done, dup, initnz;
    logic [5:0] data;
    logic [95:0] img;
    csc_pkg::csc_many_cfg_t many;
    csc_pkg::csc_once_cfg_t once;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    csc_loader csc_loader_i (.clk_i(clk), .wr_o(wr), .sel_o(sel), .data_o(data));
    csc_config_chain csc_config_chain_i (.CLK_I(clk), .RSTN_I(rstn), .CHAIN_WR_I(wr),
        .CHAIN_SEL_I(sel), .CHAIN_DATA_I(data), .MANY_CFG_O(many), .ONCE_CFG_O(once),
        .MANY_LOADED_O(loaded), .ONCE_LOCKED_O(locked), .LOAD_DONE_O(done),
        .DUP_MISMATCH_O(dup), .INIT_DUP_NONZERO_O(initnz), .CFR_REQ_I(pin[5]),
        .CPU_INTERNAL_CLOCK_TICK_I(1'h1), .FRAME_CLOCK_TICK_I(1'h1),
        .CLOCK_FORWARD_RESET_O(out[5]), .SYS_FILL_CMD_I(pin[4]), .FILL_CMD_O(out[4]),
        .SYSTEM_DATA_IN_VALID_I(pin[0]), .CACHE_CLOCK_TICK_I(1'h1), .DATA_VALID_O(out[0]),
        .SYSTEM_DATA_CONTROL_I(pin[3]), .SYSTEM_DATA_CONTROL_O(out[3]),
        .CACHE_CLK_I(pin[2]), .CACHE_CLK_O(out[2]), .SYS_ADDR_STB_I(pin[1]),
        .SYS_ADDR_STB_O(out[1]));
    ////////////////////////////////////////
    initial forever #2 clk = ~clk;
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////
    task automatic many_load();
        csc_loader_i.load(1'h0, 96'h07FBFFFFD, 6);
        chk({done, loaded}, 2'h3);
        chk(many, 18'h2FFD0);
        @(posedge clk);
        #1;
        chk({done, dup}, 2'h0);
    endtask : many_load
    task automatic init_load();
        csc_loader_i.load(1'h0, 96'h07FBFFFFF, 6);
        @(posedge clk);
        #1;
        chk(many.init_mode, 1'h1);
        chk({dup, initnz}, 2'h3);
    endtask : init_load
    task automatic once_load();
        img = 96'h0;
        img[`CSC_O_CORE+:4] = 4'h2;
        img[`CSC_O_CPU+:3] = 3'h1;
        img[`CSC_O_FRAME+:2] = 2'h1;
        img[`CSC_O_JIT] = 1'h1;
        img[`CSC_O_FILL_LO+:4] = 4'h1;
        img[`CSC_O_FILL_HI] = 1'h1;
        img[`CSC_O_DV+:2] = 2'h2;
        img[`CSC_O_BCCLK+:2] = 2'h1;
        img[`CSC_O_SYSCLK+:2] = 2'h3;
        img[`CSC_O_BCLD+:16] = 16'hA5C3;
        csc_loader_i.load(1'h1, img, 16);
        chk({locked, once.fill_command_delay}, 6'h31);
        chk(once.cache_fwd_load_vec, 16'hA5C3);
        @(posedge clk);
        #1;
        csc_loader_i.load(1'h1, {96{1'h1}}, 16);
        chk(once.fill_command_delay, 5'h11);
    endtask : once_load
    task automatic lat(input int k, input int exp);
        int n;
        n = 1;
        pin[k] = 1'h1;
        @(posedge clk);
        #1;
        pin[k] = 1'h0;
        while (out[k] !== 1'h1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, exp);
        repeat (8) @(posedge clk);
        #1;
    endtask : lat
    task automatic do_reset();
        rstn = 1'h0;
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'h1;
        chk({many, once, loaded, locked, done, dup, initnz}, 128'h0);
    endtask : do_reset
    initial begin
        do_reset();
        many_load();
        init_load();
        once_load();
        lat(5, 8);
        lat(4, 19);
        lat(3, 1);
        lat(2, 1);
        lat(1, 3);
        lat(0, 4);
        do_reset();
        lat(5, 4);
        end_of_test();
    end
endmodule : csc_config_chain_tb

/* File: verif/csc_loader.sv */
// Model of the privileged loader code that writes the chain data port.
// Assumes the bench calls load() just after a rising edge, after reset.
`timescale 1ns/10ps
module csc_loader (
    input wire logic clk_i, // core clock
    output logic wr_o, // data-port write
    output logic sel_o, // chain select
    output logic [5:0] data_o // six-bit group
);
    initial begin
        wr_o = 1'h0;
        sel_o = 1'h0;
        data_o = 6'h0;
    end
    ////////////////////////////////////////
    // Stream buffer is off and the code is cached, so writes come back to back
    task automatic load(input logic sel, input logic [95:0] img, input int n);
        sel_o = sel;
        for (int k = 0; k < n; k++) begin
            wr_o = 1'h1;
            data_o = img[6*(n-1-k)+:6];
            @(posedge clk_i);
            #1;
        end
        wr_o = 1'h0;
        // Released port shows garbage, not the last group
        data_o = ~data_o;
    endtask : load
endmodule : csc_loader
